// file: dv/ssi_properties.sv
`timescale 1ns/10ps
module ssi_properties #(
    parameter int MONO_P = 600,
    parameter int SAMPLE_P = 1000
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire logic ssi_clk, // Link clock
    input wire logic ssi_data, // Link data
    input wire logic ssi_data_oe // Device drives data
);
    import ssi_pkg::*;
    logic clk_d_ff;
    logic [15:0] quiet_ff;
    logic [15:0] gap_ff;
    logic [7:0] tog_ff;
    logic chg;
    logic fstart;
    // Clock edge, and first edge after a long rest
    assign chg = ssi_clk != clk_d_ff;
    assign fstart = chg && quiet_ff > HALF_MAX_CYC;
    always_ff @(posedge sys_clk) begin
        clk_d_ff <= ssi_clk;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) quiet_ff <= 16'hFFFF;
        else if (chg) quiet_ff <= 16'h0001;
        else if (quiet_ff != 16'hFFFF) quiet_ff <= quiet_ff + 16'h0001;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) gap_ff <= 16'hFFFF;
        else if (fstart) gap_ff <= 16'h0001;
        else if (gap_ff != 16'hFFFF) gap_ff <= gap_ff + 16'h0001;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) tog_ff <= 8'h00;
        else if (fstart) tog_ff <= 8'h01;
        else if (chg) tog_ff <= tog_ff + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_clk_rate_low: assert property (chg |-> quiet_ff >= HALF_MIN_CYC)
        else $error("clock half period too short");
    a_clk_rate_high: assert property (tog_ff[0] |-> quiet_ff <= HALF_MAX_CYC)
        else $error("clock pulse too long");
    a_read_spacing: assert property (fstart |-> gap_ff >= SAMPLE_P)
        else $error("reads too close together");
    a_monoflop_gap: assert property (fstart |-> quiet_ff >= MONO_P)
        else $error("frame started inside holdoff");
    a_rest_return: assert property (fstart |-> !tog_ff[0])
        else $error("clock did not return to rest");
    a_frame_length: assert property (fstart |-> tog_ff <= 2 * (FRAME_W + 1))
        else $error("too many clock edges in frame");
    a_data_timing: assert property (($changed(ssi_data) && $stable(ssi_data_oe)
        && ssi_data_oe) |-> (quiet_ff <= 8 || quiet_ff >= MONO_P))
        else $error("data changed away from a clock edge");
    a_idle_high: assert property ((ssi_data_oe && quiet_ff > MONO_P + 8) |-> ssi_data)
        else $error("data not idle after holdoff");
endmodule : ssi_properties

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ssi_pkg::*;
    localparam int MONO_P = 600;
    localparam int SAMPLE_P = 1000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sim_enable_setting, parity_on, parity_kind, monitor_bit_on, monitor_bit_in;
    logic clk_polarity, clk_phase, sync_request, start;
    logic [5:0] multi_turn_bit_count, single_turn_bit_count, position_resolution;
    logic [31:0] actual_position_value;
    logic [15:0] sync_shift, ctrl_period, half_period;
    logic [6:0] bit_count;
    logic encoder_sim_on, sync_locked_flag, start_ready, rx_valid, busy;
    logic ctrl_tick, sample_strobe;
    int tick_run = -1;
    int tick_gap = -1;
    logic [FRAME_W-1:0] rx_word;
    logic [FRAME_W-1:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    int seed = 30573;
    int cyc = 0;
    int r;
    ssi_if link_if ();
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    ssi_enc_device #(.MONOFLOP_CYC_P(MONO_P)) ssi_enc_device_inst (.sys_clk, .rst_n,
        .link(link_if.device), .sim_enable_setting, .multi_turn_bit_count,
        .single_turn_bit_count, .position_resolution, .parity_on, .parity_kind,
        .monitor_bit_on, .monitor_bit_in, .clk_polarity, .clk_phase, .actual_position_value,
        .sync_request, .sync_shift, .ctrl_period, .encoder_sim_on, .sync_locked_flag,
        .ctrl_tick, .sample_strobe);
    ssi_enc_host #(.MONOFLOP_CYC_P(MONO_P), .SAMPLE_CYC_P(SAMPLE_P)) ssi_enc_host_inst (
        .sys_clk, .rst_n, .link(link_if.host), .clk_polarity, .clk_phase, .half_period,
        .bit_count, .start, .start_ready, .rx_word, .rx_valid, .busy);
    ssi_properties #(.MONO_P(MONO_P), .SAMPLE_P(SAMPLE_P)) ssi_properties_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .ssi_clk(link_if.ssi_clk),
        .ssi_data(link_if.ssi_data), .ssi_data_oe(link_if.ssi_data_oe));

    // Cycles from position sample to the next control cycle start
    always @(negedge sys_clk) begin
        if (sample_strobe) tick_run = 0;
        else if (tick_run >= 0) tick_run++;
        if (ctrl_tick && tick_run >= 0) begin
            tick_gap = tick_run;
            tick_run = -1;
        end
    end

    task automatic check(input logic [FRAME_W-1:0] seen, input logic [FRAME_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Reference frame: multi-turn, single-turn, parity, monitor bit
    function automatic int model(input logic [31:0] p, output logic [FRAME_W-1:0] w);
        int mt, res, s, n;
        longint v, f;
        mt = multi_turn_bit_count;
        res = position_resolution;
        s = (mt + single_turn_bit_count > 32) ? 32 - mt : single_turn_bit_count;
        v = longint'(p) & ((64'h1 << res) - 1);
        v = (s <= res) ? v >> (res - s) : v << (s - res);
        f = (((longint'(p) >> res) & ((64'h1 << mt) - 1)) << s) | v;
        n = mt + s;
        if (parity_on) begin
            f = (f << 1) | (($countones(f) & 1) ^ parity_kind);
            n++;
        end
        if (monitor_bit_on) begin
            f = (f << 1) | monitor_bit_in;
            n++;
        end
        w = f[FRAME_W-1:0];
        return n;
    endfunction : model

    task automatic wait_for(input int lim, input bit what);
        int k;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
            if (k > lim) begin
                n_errors++;
                close_out();
            end
        end while (what ? rx_valid !== 1'b1 : start_ready !== 1'b1);
    endtask : wait_for

    task automatic frame(input bit align);
        logic [FRAME_W-1:0] w;
        int n;
        wait_for(60000, 1'b0);
        while (align && cyc % 6000 != 0) @(negedge sys_clk);
        @(posedge sys_clk);
        n = model(32'h0, w);
        r = $random(seed);
        bit_count <= n[6:0];
        actual_position_value <= 32'($random(seed));
        monitor_bit_in <= r[3];
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        n = model(actual_position_value, w);
        exp_q.push_back(sim_enable_setting ? w : 34'h0);
        wait_for(40000, 1'b1);
        check(rx_word, exp_q.pop_front());
        check({33'h0, start_ready}, 34'h0);
    endtask : frame

    task automatic cfg(input logic [5:0] mt, st, input logic [4:0] opt, input logic [15:0] hp);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        multi_turn_bit_count <= mt;
        single_turn_bit_count <= st;
        {clk_polarity, clk_phase, parity_on, parity_kind, monitor_bit_on} <= opt;
        half_period <= hp;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : cfg

    initial begin
        {start, sync_request, parity_on, parity_kind, monitor_bit_on, monitor_bit_in} = 6'h00;
        {clk_polarity, clk_phase} = 2'h0;
        sim_enable_setting = 1'b1;
        sync_shift = 16'h0000;
        ctrl_period = 16'h0258;
        actual_position_value = 32'h0;
        bit_count = 7'h20;
        half_period = 16'h0043;
        multi_turn_bit_count = DEF_MULTI_TURN_BITS;
        single_turn_bit_count = DEF_SINGLE_TURN_BITS;
        position_resolution = DEF_RESOLUTION_BITS;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        frame(1'b0);
        check({32'h0, encoder_sim_on, sync_locked_flag}, 34'h2);
        $display("test default layout done");
        for (int i = 0; i < 4; i++) begin
            cfg(6'h0C, 6'h14, {i[1], i[0], 1'b1, i[0] ^ i[1], i[1]}, 16'h0043);
            frame(1'b0);
        end
        $display("test polarity phase parity done");
        cfg(6'h08, 6'h18, 5'h00, 16'h0043);
        frame(1'b0);
        cfg(6'h10, 6'h10, 5'h00, 16'h0043);
        frame(1'b0);
        cfg(6'h03, 6'h05, 5'h06, 16'h01F4);
        frame(1'b0);
        $display("test field widths and rate done");
        @(posedge sys_clk);
        sim_enable_setting <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check({32'h0, encoder_sim_on, link_if.ssi_data_oe}, 34'h0);
        frame(1'b0);
        @(posedge sys_clk);
        sim_enable_setting <= 1'b1;
        repeat (4) @(negedge sys_clk);
        check({33'h0, encoder_sim_on}, 34'h1);
        $display("test enable done");
        cfg(6'h0C, 6'h14, 5'h00, 16'h0043);
        r = $random(seed);
        @(posedge sys_clk);
        sync_request <= 1'b1;
        sync_shift <= {7'h00, r[8:0]};
        repeat (3) frame(1'b1);
        check({33'h0, sync_locked_flag}, 34'h1);
        check(34'(tick_gap), 34'(int'(ctrl_period) - 1 - int'(sync_shift)));
        @(posedge sys_clk);
        sync_request <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check({33'h0, sync_locked_flag}, 34'h0);
        $display("test sync done");
        close_out();
    end
endmodule : tb_top

// file: hdl/ssi_enc_device.sv
`timescale 1ns/10ps
module ssi_enc_device #(
    parameter int MONOFLOP_CYC_P = ssi_pkg::MONOFLOP_CYC
) (
    input logic sys_clk, // System clock
    input logic rst_n, // Async reset
    ssi_if.device link, // SSI pins
    input logic sim_enable_setting, // Enable simulation
    input logic [5:0] multi_turn_bit_count, // Multi-turn bits sent
    input logic [5:0] single_turn_bit_count, // Single-turn bits sent
    input logic [5:0] position_resolution, // Internal single-turn bits
    input logic parity_on, // Append parity
    input logic parity_kind, // 1 odd, 0 even
    input logic monitor_bit_on, // Append monitor bit
    input logic monitor_bit_in, // Monitor bit value
    input logic clk_polarity, // Clock rest level
    input logic clk_phase, // 0 leading, 1 following
    input logic [ssi_pkg::POS_W-1:0] actual_position_value, // Position source
    input logic sync_request, // Enable sync
    input logic [ssi_pkg::CNT_W-1:0] sync_shift, // Sync offset in cycles
    input logic [ssi_pkg::CNT_W-1:0] ctrl_period, // Control cycle length
    output logic encoder_sim_on, // Simulation active
    output logic sync_locked_flag, // Locked to read cycle
    output logic ctrl_tick, // Control cycle start
    output logic sample_strobe // Position sampled
);
    import ssi_pkg::*;

    function automatic frame_s build_frame(
        input logic [POS_W-1:0] pos,
        input logic [5:0] mt,
        input logic [5:0] st,
        input logic [5:0] res,
        input logic par_on,
        input logic par_odd,
        input logic mon_on,
        input logic mon
    );
        frame_s f;
        int mtc;
        int stc;
        int rs;
        int n;
        int j;
        logic b;
        logic p;
        f = '0;
        p = 1'b0;
        rs = (int'(res) > POS_W) ? POS_W : int'(res);
        mtc = (int'(mt) > POS_W) ? POS_W : int'(mt);
        stc = (int'(st) > POS_W - mtc) ? POS_W - mtc : int'(st);
        for (int k = 0; k < POS_W; k++) begin
            b = 1'b0;
            if (k < mtc) begin
                j = mtc - 1 - k;
                if (j < POS_W - rs) begin
                    b = pos[rs + j];
                end
            end else if (k < mtc + stc) begin
                j = k - mtc;
                if (j < rs) begin
                    b = pos[rs - 1 - j];
                end
            end
            f.bits[FRAME_W - 1 - k] = b;
            p = p ^ b;
        end
        n = mtc + stc;
        if (par_on) begin
            f.bits[FRAME_W - 1 - n] = p ^ par_odd;
            n = n + 1;
        end
        if (mon_on) begin
            f.bits[FRAME_W - 1 - n] = mon;
            n = n + 1;
        end
        f.len = LEN_W'(n);
        return f;
    endfunction : build_frame

    function automatic logic [IDX_W-1:0] gray_to_bin(input logic [IDX_W-1:0] g);
        logic [IDX_W-1:0] b;
        b = '0;
        b[IDX_W-1] = g[IDX_W-1];
        for (int k = IDX_W - 2; k >= 0; k--) begin
            b[k] = b[k+1] ^ g[k];
        end
        return b;
    endfunction : gray_to_bin

    // Sys domain state
    logic frame_clr_ff;
    logic clk_meta_ff;
    logic clk_sync_ff;
    logic clk_prev_ff;
    logic [IDX_W-1:0] gray_meta_ff;
    logic [IDX_W-1:0] gray_sync_ff;
    logic [31:0] quiet_cnt_ff;
    frame_s frame_ff;
    logic data_ff;
    logic data_oe_ff;
    logic sample_ff;
    logic locked_ff;
    logic [CNT_W-1:0] ctrl_cnt_ff;

    // Link domain state
    logic [IDX_W-1:0] lbin_ff;
    logic [IDX_W-1:0] lgray_ff;
    logic [IDX_W-1:0] nxt_lbin;
    logic change_clk;

    logic clk_away;
    logic clk_toggled;
    logic start_det;
    logic [LEN_W-1:0] bit_pos;
    logic [LEN_W-1:0] bit_sel;
    logic nxt_data;
    logic [CNT_W-1:0] phase_err;
    logic near_lock;
    logic [CNT_W-1:0] sync_load;

    // Change edge is a rising edge of this clock
    assign change_clk = link.ssi_clk ^ (clk_polarity ^ clk_phase);

    assign nxt_lbin = (lbin_ff == '1) ? lbin_ff : lbin_ff + 1'b1;

    // Bit counter, cleared while no frame runs
    always_ff @(posedge change_clk or posedge frame_clr_ff) begin
        if (frame_clr_ff) begin
            lbin_ff <= '0;
            lgray_ff <= '0;
        end else begin
            lbin_ff <= nxt_lbin;
            lgray_ff <= nxt_lbin ^ (nxt_lbin >> 1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_meta_ff <= 1'b0;
            clk_sync_ff <= 1'b0;
            clk_prev_ff <= 1'b0;
            gray_meta_ff <= '0;
            gray_sync_ff <= '0;
        end else begin
            clk_meta_ff <= link.ssi_clk;
            clk_sync_ff <= clk_meta_ff;
            clk_prev_ff <= clk_sync_ff;
            gray_meta_ff <= lgray_ff;
            gray_sync_ff <= gray_meta_ff;
        end
    end

    assign clk_away = clk_sync_ff != clk_polarity;
    assign clk_toggled = clk_sync_ff != clk_prev_ff;
    // Needs a real toggle: sync flops reset low even when the clock rests high
    assign start_det = frame_clr_ff && sim_enable_setting && clk_away && clk_toggled;

    // Frame start and monoflop end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_clr_ff <= 1'b1;
            quiet_cnt_ff <= '0;
        end else if (!sim_enable_setting) begin
            frame_clr_ff <= 1'b1;
            quiet_cnt_ff <= '0;
        end else if (start_det) begin
            frame_clr_ff <= 1'b0;
            quiet_cnt_ff <= '0;
        end else if (!frame_clr_ff) begin
            if (clk_toggled || clk_away) begin
                quiet_cnt_ff <= '0;
            end else if (quiet_cnt_ff >= 32'(MONOFLOP_CYC_P - 1)) begin
                frame_clr_ff <= 1'b1;
                quiet_cnt_ff <= '0;
            end else begin
                quiet_cnt_ff <= quiet_cnt_ff + 32'h1;
            end
        end
    end

    // Position latched at the first clock edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_ff <= '0;
            sample_ff <= 1'b0;
        end else begin
            sample_ff <= start_det;
            if (start_det) begin
                frame_ff <= build_frame(actual_position_value, multi_turn_bit_count,
                    single_turn_bit_count, position_resolution, parity_on, parity_kind,
                    monitor_bit_on, monitor_bit_in);
            end
        end
    end

    // Leading-edge change loses its first edge to the clear
    assign bit_pos = LEN_W'(gray_to_bin(gray_sync_ff)) + (clk_phase ? 7'h00 : 7'h01);
    assign bit_sel = LEN_W'(FRAME_W) - bit_pos;

    always_comb begin
        if (frame_clr_ff || bit_pos == '0) begin
            nxt_data = 1'b1;
        end else if (bit_pos <= frame_ff.len) begin
            nxt_data = frame_ff.bits[bit_sel[5:0]];
        end else begin
            nxt_data = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= 1'b1;
            data_oe_ff <= 1'b0;
        end else begin
            data_ff <= nxt_data;
            data_oe_ff <= sim_enable_setting;
        end
    end

    // Control cycle counter with sync alignment
    assign phase_err = (ctrl_cnt_ff >= sync_shift) ? ctrl_cnt_ff - sync_shift
                                                   : sync_shift - ctrl_cnt_ff;
    assign near_lock = phase_err <= CNT_W'(SYNC_TOL_CYC) ||
        (phase_err < ctrl_period && ctrl_period - phase_err <= CNT_W'(SYNC_TOL_CYC));
    // Loaded one ahead, so the start edge itself sits at the offset
    assign sync_load = (sync_shift >= ctrl_period - 1'b1) ? '0 : sync_shift + 1'b1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_cnt_ff <= '0;
        end else if (start_det && sync_request && !near_lock) begin
            ctrl_cnt_ff <= sync_load;
        end else if (ctrl_cnt_ff >= ctrl_period - 1'b1) begin
            ctrl_cnt_ff <= '0;
        end else begin
            ctrl_cnt_ff <= ctrl_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_ff <= 1'b0;
        end else if (!sync_request || !sim_enable_setting) begin
            locked_ff <= 1'b0;
        end else if (start_det) begin
            locked_ff <= near_lock;
        end
    end

    assign link.ssi_data = data_ff;
    assign link.ssi_data_oe = data_oe_ff;
    assign encoder_sim_on = data_oe_ff;
    assign sync_locked_flag = locked_ff;
    assign ctrl_tick = ctrl_cnt_ff == '0;
    assign sample_strobe = sample_ff;

endmodule : ssi_enc_device

// file: hdl/ssi_enc_host.sv
`timescale 1ns/10ps
module ssi_enc_host #(
    parameter int MONOFLOP_CYC_P = ssi_pkg::MONOFLOP_CYC,
    parameter int SAMPLE_CYC_P = ssi_pkg::SAMPLE_MIN_CYC
) (
    input logic sys_clk, // System clock
    input logic rst_n, // Async reset
    ssi_if.host link, // SSI pins
    input logic clk_polarity, // Clock rest level
    input logic clk_phase, // Device change edge
    input logic [ssi_pkg::CNT_W-1:0] half_period, // Half bit time in cycles
    input logic [ssi_pkg::LEN_W-1:0] bit_count, // Bits per word
    input logic start, // Read request
    output logic start_ready, // Request accepted now
    output logic [ssi_pkg::FRAME_W-1:0] rx_word, // Word, right aligned
    output logic rx_valid, // Word done pulse
    output logic busy // Transfer or holdoff
);
    import ssi_pkg::*;

    host_state_e state_ff;
    logic clk_ff;
    logic data_meta_ff;
    logic data_sync_ff;
    logic [CNT_W-1:0] half_cnt_ff;
    logic [LEN_W:0] edge_cnt_ff;
    logic [31:0] gap_cnt_ff;
    logic [31:0] samp_cnt_ff;
    logic [FRAME_W-1:0] sh_ff;
    logic [FRAME_W-1:0] rx_word_ff;
    logic rx_valid_ff;

    logic [CNT_W-1:0] hp;
    logic [LEN_W-1:0] nbits;
    logic [LEN_W:0] total_edges;
    logic [LEN_W:0] edge_num;
    logic edge_now;
    logic take_bit;
    logic [FRAME_W-1:0] nxt_sh;

    // Rate kept inside the supported band
    assign hp = (half_period < CNT_W'(HALF_MIN_CYC)) ? CNT_W'(HALF_MIN_CYC) :
                (half_period > CNT_W'(HALF_MAX_CYC)) ? CNT_W'(HALF_MAX_CYC) : half_period;
    assign nbits = (bit_count == '0) ? 7'h01 :
                   (bit_count > LEN_W'(FRAME_W)) ? LEN_W'(FRAME_W) : bit_count;
    assign total_edges = {nbits + LEN_W'(clk_phase), 1'b0};
    assign edge_num = edge_cnt_ff + 1'b1;
    assign edge_now = state_ff == H_RUN && half_cnt_ff >= hp - 1'b1;
    // Sample on the edge opposite the device change edge
    assign take_bit = edge_now && (clk_phase ? (edge_num[0] && edge_num != 8'h01) : !edge_num[0]);
    assign nxt_sh = take_bit ? {sh_ff[FRAME_W-2:0], data_sync_ff} : sh_ff;
    assign start_ready = state_ff == H_IDLE && samp_cnt_ff >= 32'(SAMPLE_CYC_P - 1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_meta_ff <= 1'b1;
            data_sync_ff <= 1'b1;
        end else begin
            data_meta_ff <= link.ssi_data & link.ssi_data_oe;
            data_sync_ff <= data_meta_ff;
        end
    end

    // Interval between read starts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_cnt_ff <= 32'(SAMPLE_CYC_P - 1);
        end else if (start && start_ready) begin
            samp_cnt_ff <= '0;
        end else if (samp_cnt_ff < 32'(SAMPLE_CYC_P - 1)) begin
            samp_cnt_ff <= samp_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= H_IDLE;
            clk_ff <= 1'b0;
            half_cnt_ff <= '0;
            edge_cnt_ff <= '0;
            gap_cnt_ff <= '0;
            sh_ff <= '0;
        end else begin
            unique case (state_ff)
                H_IDLE: begin
                    clk_ff <= 1'b0;
                    if (start && start_ready) begin
                        state_ff <= H_RUN;
                        half_cnt_ff <= '0;
                        edge_cnt_ff <= '0;
                        sh_ff <= '0;
                    end
                end
                H_RUN: begin
                    sh_ff <= nxt_sh;
                    if (edge_now) begin
                        half_cnt_ff <= '0;
                        clk_ff <= ~clk_ff;
                        edge_cnt_ff <= edge_num;
                        if (edge_num == total_edges) begin
                            state_ff <= H_GAP;
                            gap_cnt_ff <= '0;
                        end
                    end else begin
                        half_cnt_ff <= half_cnt_ff + 1'b1;
                    end
                end
                H_GAP: begin
                    if (gap_cnt_ff >= 32'(MONOFLOP_CYC_P - 1)) begin
                        state_ff <= H_IDLE;
                    end else begin
                        gap_cnt_ff <= gap_cnt_ff + 32'h1;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_word_ff <= '0;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= edge_now && edge_num == total_edges;
            if (edge_now && edge_num == total_edges) begin
                rx_word_ff <= nxt_sh;
            end
        end
    end

    assign link.ssi_clk = clk_ff ^ clk_polarity;
    assign rx_word = rx_word_ff;
    assign rx_valid = rx_valid_ff;
    assign busy = state_ff != H_IDLE;

endmodule : ssi_enc_host

// file: pkg/ssi_if.sv
`timescale 1ns/10ps
interface ssi_if;
    logic ssi_clk;
    logic ssi_data;
    logic ssi_data_oe;

    modport device (
        input ssi_clk,
        output ssi_data,
        output ssi_data_oe
    );

    modport host (
        output ssi_clk,
        input ssi_data,
        input ssi_data_oe
    );
endinterface : ssi_if

// file: pkg/ssi_pkg.sv
package ssi_pkg;

    localparam int POS_W = 32;
    localparam int FRAME_W = POS_W + 2;
    localparam int IDX_W = 6;
    localparam int LEN_W = 7;
    localparam int CNT_W = 16;

    localparam logic [5:0] DEF_MULTI_TURN_BITS = 6'h0C;
    localparam logic [5:0] DEF_SINGLE_TURN_BITS = 6'h14;
    localparam logic [5:0] DEF_RESOLUTION_BITS = 6'h14;
    localparam int DEF_RESOLUTION_INC = 1048576;

    localparam int SYS_CLK_KHZ = 200000;
    localparam int MONOFLOP_US = 25;
    localparam int SAMPLE_MIN_US = 125;
    localparam int RATE_MIN_KBPS = 200;
    localparam int RATE_MAX_KBPS = 1500;

    localparam int MONOFLOP_CYC = MONOFLOP_US * SYS_CLK_KHZ / 1000;
    localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int HALF_MIN_CYC = (SYS_CLK_KHZ + 2 * RATE_MAX_KBPS - 1) / (2 * RATE_MAX_KBPS);
    localparam int HALF_MAX_CYC = SYS_CLK_KHZ / (2 * RATE_MIN_KBPS);

    localparam int SYNC_TOL_CYC = 2;

    typedef struct packed {
        logic [FRAME_W-1:0] bits;
        logic [LEN_W-1:0] len;
    } frame_s;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RUN = 2'b01,
        H_GAP = 2'b10
    } host_state_e;

endpackage : ssi_pkg
